// ==== verilog/tisc_top.sv ====
// Core idle state coordinator for a two-thread core.
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - With multithreading on, core halts only when both threads idle; any active thread keeps core active.
// - Each thread enters idle alone by halt or monitor-wait request.
// - Core goes deeper only when every live thread requests deeper than current.
// - One central controller moves the whole core into the agreed state.
// - Level-register reads become monitor-wait requests; no external bus read issued.
// - Level-register reads need no armed monitor address.
// - Level-register read hint comes from a firmware-set configuration input.
// - Halted thread wakes on wrap-mask change, init, INTR, NMI, probe, SMI, APIC.
// - With multithreading off, thread 1 is held active and requests reach the core through thread 0 alone.
// - Only two idle states exist: active and halted; nothing deeper.
// - Wake on interrupt, or on monitored-address access after monitor-wait entry.
// - An interrupt wakes only its own thread; core then resolves active.
// - Halted core serves snoops in a brief sub-state, then returns halted.
module tisc_top
    import tisc_pkg::*;
#(
    parameter int HINT_W = TISC_HINT_W
) (
    // Clock and reset
    input  wire logic [0:0]          CORE_CLK_I,
    input  wire logic                RESETN_I,
    // Configuration
    input  wire logic                SMT_ENABLE_I,
    input  wire logic [HINT_W-1:0]   LEVEL_HINT_CFG_I,
    // Idle requests, one bit per thread; monitor-wait hints HINT_W bits per thread
    input  wire logic [1:0]          HALT_REQ_I,
    input  wire logic [1:0]          MONITOR_WAIT_INSTRUCTION_REQ_I,
    input  wire logic [2*HINT_W-1:0] MONITOR_WAIT_INSTRUCTION_HINT_I,
    input  wire logic [1:0]          LEVEL_READ_I,
    // Wake events, one bit per thread
    input  wire logic [1:0]          ADDR_WRAP_MASK_CHG_I,
    input  wire logic [1:0]          INIT_REQ_I,
    input  wire logic [1:0]          INTR_I,
    input  wire logic [1:0]          NMI_I,
    input  wire logic [1:0]          PROBE_REQ_I,
    input  wire logic [1:0]          SYSTEM_MGMT_INTERRUPT_I,
    input  wire logic [1:0]          APIC_INT_I,
    input  wire logic [1:0]          MONITOR_HIT_I,
    // Snoops
    input  wire logic                SNOOP_REQ_I,
    // Thread and core status
    output logic      [1:0]          THREAD_IDLE_O,
    output logic      [1:0]          THREAD_VIA_MONITOR_WAIT_INSTRUCTION_O,
    output logic      [2*HINT_W-1:0] THREAD_HINT_O,
    output logic      [1:0]          CORE_STATE_O,
    output logic                     CORE_CLK_GATE_O,
    output logic                     SNOOP_ACK_O,
    output logic                     LEVEL_BUS_READ_O
);

    // ************************************************************
    // Per-thread trackers
    // ************************************************************
    logic [1:0]       idle_w;
    logic [1:0]       via_monitor_wait_instruction_w;
    logic [1:0]       thread_en;
    tisc_core_state_t core_reg;
    tisc_core_state_t core_next;
    logic             snoop_ack_reg;
    logic [1:0]       thread_idle_reg;
    logic [1:0]       via_monitor_wait_instruction_reg;
    logic [2*HINT_W-1:0] hint_reg;
    logic [2*HINT_W-1:0] hint_w;

    // With multithreading off, thread 1 never runs and requests go to the core
    // through thread 0 alone.
    assign thread_en = {SMT_ENABLE_I, 1'b1};

    // Any single wake source is enough to end a thread's idle state.
    function automatic logic wake_event(input logic [6:0] ev);
        wake_event = |ev;
    endfunction

    // ************************************************************
    // Per-thread request and wake routing
    // ************************************************************
    for (genvar t = 0; t < TISC_THREADS; t++) begin : g_thr
        tisc_thread_if #(.HINT_W(HINT_W)) thr_if ();
        logic [6:0]                       wake_vec;

        assign thr_if.halt_req    = HALT_REQ_I[t] & thread_en[t];
        assign thr_if.monitor_wait_instruction_req   = MONITOR_WAIT_INSTRUCTION_REQ_I[t] & thread_en[t];
        assign thr_if.monitor_wait_instruction_hint  = MONITOR_WAIT_INSTRUCTION_HINT_I[t*HINT_W +: HINT_W];
        assign thr_if.level_read  = LEVEL_READ_I[t] & thread_en[t];
        assign thr_if.level_hint  = LEVEL_HINT_CFG_I;
        // Each thread sees only its own wake lines.
        assign wake_vec[6] = ADDR_WRAP_MASK_CHG_I[t];
        assign wake_vec[5] = INIT_REQ_I[t];
        assign wake_vec[4] = INTR_I[t];
        assign wake_vec[3] = NMI_I[t];
        assign wake_vec[2] = PROBE_REQ_I[t];
        assign wake_vec[1] = SYSTEM_MGMT_INTERRUPT_I[t];
        assign wake_vec[0] = APIC_INT_I[t];
        // A disabled thread is held active so no stale idle state survives.
        assign thr_if.halt_break  = wake_event(wake_vec) | ~thread_en[t];
        assign thr_if.monitor_hit = MONITOR_HIT_I[t];

        tisc_thread #(
            .HINT_W (HINT_W)
        ) u_thread (
            .clk_i   (CORE_CLK_I[0]),
            .rst_n_i (RESETN_I),
            .th      (thr_if)
        );

        assign idle_w[t]                     = thr_if.idle;
        assign via_monitor_wait_instruction_w[t]                = thr_if.via_monitor_wait_instruction;
        assign hint_w[t*HINT_W +: HINT_W]    = thr_if.hint;
    end

    // ************************************************************
    // Core state resolution
    // ************************************************************
    function automatic logic resolve_depth(input logic [1:0] idle, input logic smt);
        // The core depth is the shallowest live thread depth; with multithreading off, thread 0 alone decides.
        resolve_depth = smt ? (idle[0] & idle[1]) : idle[0];
    endfunction

    logic agreed_depth;
    logic cur_depth;

    assign agreed_depth = resolve_depth(idle_w, SMT_ENABLE_I);
    // The snoop sub-state counts as halted depth, so requests never re-enter halted.
    assign cur_depth    = (core_reg == TISC_CORE_ACTIVE) ? TISC_DEPTH_ACTIVE
                                                         : TISC_DEPTH_HALTED;

    always_comb begin
        core_next = core_reg;
        case (core_reg)
            TISC_CORE_ACTIVE: begin
                // Deeper only when every live thread asks for more than now.
                if (agreed_depth > cur_depth) begin
                    core_next = TISC_CORE_HALTED;
                end
            end
            TISC_CORE_HALTED: begin
                // A wake wins over a snoop; clocks run again in the active state anyway.
                if (agreed_depth == TISC_DEPTH_ACTIVE) begin
                    core_next = TISC_CORE_ACTIVE;
                end else if (SNOOP_REQ_I) begin
                    core_next = TISC_CORE_SNOOP;
                end
            end
            TISC_CORE_SNOOP: begin
                // One cycle with clocks running, then back unless a thread woke.
                if (agreed_depth == TISC_DEPTH_ACTIVE) begin
                    core_next = TISC_CORE_ACTIVE;
                end else begin
                    core_next = TISC_CORE_HALTED;
                end
            end
            default: begin
                core_next = TISC_CORE_ACTIVE;
            end
        endcase
    end

    always_ff @(posedge CORE_CLK_I[0] or negedge RESETN_I) begin
        if (!RESETN_I) begin
            core_reg <= TISC_CORE_ACTIVE;
        end else begin
            core_reg <= core_next;
        end
    end

    // ************************************************************
    // Snoop acknowledge
    // ************************************************************
    always_ff @(posedge CORE_CLK_I[0] or negedge RESETN_I) begin
        if (!RESETN_I) begin
            snoop_ack_reg <= 1'b0;
        end else begin
            snoop_ack_reg <= (core_next == TISC_CORE_SNOOP);
        end
    end

    // ************************************************************
    // Registered status outputs
    // ************************************************************
    always_ff @(posedge CORE_CLK_I[0] or negedge RESETN_I) begin
        if (!RESETN_I) begin
            thread_idle_reg <= 2'h0;
        end else begin
            thread_idle_reg <= idle_w;
        end
    end

    always_ff @(posedge CORE_CLK_I[0] or negedge RESETN_I) begin
        if (!RESETN_I) begin
            via_monitor_wait_instruction_reg <= 2'h0;
        end else begin
            via_monitor_wait_instruction_reg <= via_monitor_wait_instruction_w;
        end
    end

    always_ff @(posedge CORE_CLK_I[0] or negedge RESETN_I) begin
        if (!RESETN_I) begin
            hint_reg <= '0;
        end else begin
            hint_reg <= hint_w;
        end
    end

    // ************************************************************
    // Port drive
    // ************************************************************
    assign THREAD_IDLE_O      = thread_idle_reg;
    assign THREAD_VIA_MONITOR_WAIT_INSTRUCTION_O = via_monitor_wait_instruction_reg;
    assign THREAD_HINT_O      = hint_reg;
    assign CORE_STATE_O       = core_reg;
    // The gate follows the state flop, so the snoop sub-state ungates at once.
    assign CORE_CLK_GATE_O    = (core_reg == TISC_CORE_HALTED);
    assign SNOOP_ACK_O        = snoop_ack_reg;
    // Level reads are absorbed internally and never reach the bus.
    assign LEVEL_BUS_READ_O   = 1'b0;

endmodule
`default_nettype wire

// ==== verilog/tisc_pkg.sv ====
// Shared constants and state types for the thread idle state coordinator.
`default_nettype none
package tisc_pkg;

    // ************************************************************
    // Widths and reset values
    // ************************************************************
    localparam int           TISC_THREADS   = 2;
    localparam int           TISC_HINT_W    = 4;
    localparam logic [3:0]   TISC_HINT_RST  = 4'h0;
    localparam logic         TISC_SMT_RST   = 1'b1;

    // ************************************************************
    // State encodings
    // ************************************************************
    typedef enum logic [1:0] {
        TISC_THREAD_ACTIVE = 2'b00,
        TISC_THREAD_HALT   = 2'b01,
        TISC_THREAD_MONITOR_WAIT_INSTRUCTION  = 2'b10
    } tisc_thread_state_t;

    typedef enum logic [1:0] {
        TISC_CORE_ACTIVE = 2'b00,
        TISC_CORE_HALTED = 2'b01,
        TISC_CORE_SNOOP  = 2'b10
    } tisc_core_state_t;

    // Numeric depth of the core active and core halted states.
    localparam logic         TISC_DEPTH_ACTIVE = 1'b0;
    localparam logic         TISC_DEPTH_HALTED = 1'b1;

endpackage
`default_nettype wire

// ==== verilog/tisc_thread_if.sv ====
// Carrier between the coordinator and one per-thread idle tracker.
`timescale 1ns/1ns
`default_nettype none
interface tisc_thread_if
    import tisc_pkg::*;
#(
    parameter int HINT_W = TISC_HINT_W
);
    logic              halt_req;
    logic              monitor_wait_instruction_req;
    logic [HINT_W-1:0] monitor_wait_instruction_hint;
    logic              level_read;
    logic [HINT_W-1:0] level_hint;
    logic              halt_break;
    logic              monitor_hit;
    logic              idle;
    logic              via_monitor_wait_instruction;
    logic [HINT_W-1:0] hint;

    modport thread (
        input  halt_req, monitor_wait_instruction_req, monitor_wait_instruction_hint, level_read, level_hint,
        input  halt_break, monitor_hit,
        output idle, via_monitor_wait_instruction, hint
    );
    modport core (
        output halt_req, monitor_wait_instruction_req, monitor_wait_instruction_hint, level_read, level_hint,
        output halt_break, monitor_hit,
        input  idle, via_monitor_wait_instruction, hint
    );
endinterface
`default_nettype wire

// ==== verilog/tisc_thread.sv ====
// Idle state tracker for one hardware thread.
`timescale 1ns/1ns
`default_nettype none
module tisc_thread
    import tisc_pkg::*;
#(
    parameter int HINT_W = TISC_HINT_W
) (
    // Clock and reset
    input  wire logic      clk_i,
    input  wire logic      rst_n_i,
    // Thread side of the carrier
    tisc_thread_if.thread  th
);

    tisc_thread_state_t  state_reg;
    tisc_thread_state_t  state_next;
    logic [HINT_W-1:0]   hint_reg;
    logic [HINT_W-1:0]   hint_next;

    always_comb begin
        state_next = state_reg;
        hint_next  = hint_reg;
        case (state_reg)
            TISC_THREAD_ACTIVE: begin
                if (th.halt_req) begin
                    state_next = TISC_THREAD_HALT;
                end else if (th.monitor_wait_instruction_req) begin
                    state_next = TISC_THREAD_MONITOR_WAIT_INSTRUCTION;
                    hint_next  = th.monitor_wait_instruction_hint;
                end else if (th.level_read) begin
                    // No monitor arming is checked on this path.
                    state_next = TISC_THREAD_MONITOR_WAIT_INSTRUCTION;
                    hint_next  = th.level_hint;
                end
            end
            TISC_THREAD_HALT: begin
                if (th.halt_break) begin
                    state_next = TISC_THREAD_ACTIVE;
                end
            end
            TISC_THREAD_MONITOR_WAIT_INSTRUCTION: begin
                if (th.halt_break || th.monitor_hit) begin
                    state_next = TISC_THREAD_ACTIVE;
                end
            end
            default: begin
                state_next = TISC_THREAD_ACTIVE;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg <= TISC_THREAD_ACTIVE;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hint_reg <= HINT_W'(TISC_HINT_RST);
        end else begin
            hint_reg <= hint_next;
        end
    end

    // Any hint deeper than halted still only reaches the single idle state.
    assign th.idle      = (state_reg != TISC_THREAD_ACTIVE);
    assign th.via_monitor_wait_instruction = (state_reg == TISC_THREAD_MONITOR_WAIT_INSTRUCTION);
    assign th.hint      = hint_reg;

endmodule
`default_nettype wire

// ==== verification/tisc_top_monitor.sv ====
// Concurrent checks on the ports of the idle state coordinator.
`timescale 1ns/1ns
`default_nettype none
module tisc_monitor
    import tisc_pkg::*;
(
    // Clock and reset
    input  wire logic [0:0] CORE_CLK_I,
    input  wire logic       RESETN_I,
    // Watched ports
    input  wire logic       SMT_ENABLE_I,
    input  wire logic [1:0] HALT_REQ_I,
    input  wire logic [1:0] MONITOR_WAIT_INSTRUCTION_REQ_I,
    input  wire logic [1:0] LEVEL_READ_I,
    input  wire logic [1:0] INTR_I,
    input  wire logic [1:0] MONITOR_HIT_I,
    input  wire logic       SNOOP_REQ_I,
    input  wire logic [1:0] THREAD_IDLE_O,
    input  wire logic [1:0] THREAD_VIA_MONITOR_WAIT_INSTRUCTION_O,
    input  wire logic [1:0] CORE_STATE_O,
    input  wire logic       CORE_CLK_GATE_O,
    input  wire logic       SNOOP_ACK_O,
    input  wire logic       LEVEL_BUS_READ_O
);
    // A pending entry request re-idles the thread right after a wake, so it masks the wake checks.
    wire logic [1:0] req = HALT_REQ_I | MONITOR_WAIT_INSTRUCTION_REQ_I | LEVEL_READ_I;

    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (!RESETN_I);

    a_gate_on_halt: assert property (
        CORE_CLK_GATE_O == (CORE_STATE_O == TISC_CORE_HALTED))
        else $error("Clock gate differs from halted core state.");
    a_both_idle: assert property (
        SMT_ENABLE_I && CORE_STATE_O == TISC_CORE_HALTED |-> THREAD_IDLE_O == 2'b11)
        else $error("Core halted without both threads idle.");
    a_no_bus_read: assert property (!LEVEL_BUS_READ_O)
        else $error("External read issued for a level read.");
    a_two_states: assert property (CORE_STATE_O != 2'b11)
        else $error("Core entered an unknown deeper state.");
    a_snoop_ack: assert property (
        SNOOP_ACK_O == (CORE_STATE_O == TISC_CORE_SNOOP))
        else $error("Snoop acknowledge differs from snoop sub-state.");
    a_snoop_brief: assert property (
        CORE_STATE_O == TISC_CORE_SNOOP |=> CORE_STATE_O != TISC_CORE_SNOOP)
        else $error("Snoop sub-state held too long.");
    a_snoop_entry: assert property (
        CORE_STATE_O == TISC_CORE_HALTED && SNOOP_REQ_I |=> CORE_STATE_O == TISC_CORE_SNOOP)
        else $error("Halted core ignored a snoop.");
    a_intr_wake: assert property (
        THREAD_IDLE_O[0] && INTR_I[0] && !req[0] |-> ##2 !THREAD_IDLE_O[0])
        else $error("Interrupt did not wake thread zero.");
    a_wake_alone: assert property (
        SMT_ENABLE_I && THREAD_IDLE_O == 2'b11 && INTR_I == 2'b01 && !req[0]
        && !MONITOR_HIT_I[1] |-> ##2 (THREAD_IDLE_O == 2'b10 && CORE_STATE_O == 2'b00))
        else $error("Interrupt woke the wrong thread or core stayed halted.");
    a_monitor_wake: assert property (
        SMT_ENABLE_I && THREAD_IDLE_O[1] && THREAD_VIA_MONITOR_WAIT_INSTRUCTION_O[1] && MONITOR_HIT_I[1]
        && !req[1] |-> ##2 !THREAD_IDLE_O[1])
        else $error("Monitor hit did not wake thread one.");
endmodule
bind tisc_top tisc_monitor i_tisc_monitor (
    .CORE_CLK_I(CORE_CLK_I), .RESETN_I(RESETN_I), .SMT_ENABLE_I(SMT_ENABLE_I),
    .HALT_REQ_I(HALT_REQ_I), .MONITOR_WAIT_INSTRUCTION_REQ_I(MONITOR_WAIT_INSTRUCTION_REQ_I), .LEVEL_READ_I(LEVEL_READ_I),
    .INTR_I(INTR_I), .MONITOR_HIT_I(MONITOR_HIT_I), .SNOOP_REQ_I(SNOOP_REQ_I),
    .THREAD_IDLE_O(THREAD_IDLE_O), .THREAD_VIA_MONITOR_WAIT_INSTRUCTION_O(THREAD_VIA_MONITOR_WAIT_INSTRUCTION_O),
    .CORE_STATE_O(CORE_STATE_O), .CORE_CLK_GATE_O(CORE_CLK_GATE_O),
    .SNOOP_ACK_O(SNOOP_ACK_O), .LEVEL_BUS_READ_O(LEVEL_BUS_READ_O));
`default_nettype wire

// ==== verification/tisc_top_tb.sv ====
// Self-checking bench for the idle state coordinator.
`timescale 1ns/1ns
`default_nettype none
module tisc_top_tb
    import tisc_pkg::*;
;
    logic       clk = 1'b0, rst_n = 1'b0, smt = 1'b1, snoop = 1'b0;
    logic [3:0] cfg = 4'h0;
    logic [1:0] halt = 2'h0, mw = 2'h0, lvl = 2'h0, hit = 2'h0;
    logic [7:0] mhint = 8'h00;
    logic [1:0] wk [0:6];
    logic [1:0] idle, via, cst;
    logic [7:0] hint;
    logic       gate, ack, busrd;
    int         bad_count = 0, n_tests = 0;

    always #50 clk = ~clk;

    tisc_top i_tisc_top (
        .CORE_CLK_I(clk), .RESETN_I(rst_n), .SMT_ENABLE_I(smt), .LEVEL_HINT_CFG_I(cfg),
        .HALT_REQ_I(halt), .MONITOR_WAIT_INSTRUCTION_REQ_I(mw), .MONITOR_WAIT_INSTRUCTION_HINT_I(mhint), .LEVEL_READ_I(lvl),
        .ADDR_WRAP_MASK_CHG_I(wk[0]), .INIT_REQ_I(wk[1]), .INTR_I(wk[2]), .NMI_I(wk[3]),
        .PROBE_REQ_I(wk[4]), .SYSTEM_MGMT_INTERRUPT_I(wk[5]), .APIC_INT_I(wk[6]),
        .MONITOR_HIT_I(hit), .SNOOP_REQ_I(snoop), .THREAD_IDLE_O(idle),
        .THREAD_VIA_MONITOR_WAIT_INSTRUCTION_O(via), .THREAD_HINT_O(hint), .CORE_STATE_O(cst),
        .CORE_CLK_GATE_O(gate), .SNOOP_ACK_O(ack), .LEVEL_BUS_READ_O(busrd));

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Requests are taken at one edge and show at the ports after the next.
    task automatic go();
        @(negedge clk);
        halt = 2'h0;
        mw = 2'h0;
        lvl = 2'h0;
        hit = 2'h0;
        foreach (wk[i]) wk[i] = 2'h0;
        @(negedge clk);
    endtask

    task automatic st(input logic [1:0] ei, input logic [1:0] ec);
        chk("thread idle", {6'h00, ei}, {6'h00, idle});
        chk("core state", {6'h00, ec}, {6'h00, cst});
        chk("clock gate", {7'h00, ec == 2'h1}, {7'h00, gate});
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_halt_snoop();
        halt = 2'h1;
        go();
        st(2'h1, 2'h0);
        halt = 2'h2;
        go();
        st(2'h3, 2'h1);
        snoop = 1'b1;
        @(negedge clk);
        snoop = 1'b0;
        chk("snoop state", 8'h02, {6'h00, cst});
        chk("snoop ack", 8'h01, {7'h00, ack});
        @(negedge clk);
        st(2'h3, 2'h1);
        wk[2] = 2'h3;
        go();
        st(2'h0, 2'h0);
    endtask

    task automatic t_wakes();
        for (int k = 0; k < 7; k++) begin
            halt = 2'h3;
            go();
            st(2'h3, 2'h1);
            wk[k] = 2'h1;
            go();
            st(2'h2, 2'h0);
            wk[k] = 2'h2;
            go();
            st(2'h0, 2'h0);
        end
    endtask

    task automatic t_paths();
        cfg = 4'hA;
        lvl = 2'h1;
        mw = 2'h2;
        mhint = 8'hF0;
        go();
        st(2'h3, 2'h1);
        chk("via wait", 8'h03, {6'h00, via});
        chk("hint", 8'hFA, hint);
        chk("bus read", 8'h00, {7'h00, busrd});
        hit = 2'h1;
        go();
        st(2'h2, 2'h0);
        halt = 2'h1;
        go();
        st(2'h3, 2'h1);
        hit = 2'h3;
        go();
        st(2'h1, 2'h0);
        wk[1] = 2'h1;
        go();
        st(2'h0, 2'h0);
    endtask

    task automatic t_smt_off();
        smt = 1'b0;
        halt = 2'h3;
        go();
        st(2'h1, 2'h1);
        wk[3] = 2'h1;
        go();
        st(2'h0, 2'h0);
        smt = 1'b1;
    endtask

    // ****************************************************************
    // Main sequence and watchdog
    // ****************************************************************
    initial begin
        repeat (2000) @(posedge clk);
        bad_count++;
        $display("MISMATCH run expected done seen running");
        close_out();
    end

    initial begin
        foreach (wk[i]) wk[i] = 2'h0;
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        st(2'h0, 2'h0);
        chk("reset status", 8'h00, {4'h0, via, ack, busrd});
        t_halt_snoop();
        t_wakes();
        t_paths();
        t_smt_off();
        close_out();
    end
endmodule
`default_nettype wire
